//--- common/spc_pkg.sv
package spc_pkg;

  localparam int SPC_BYTE_W = 8;
  localparam int SPC_CNT_W = 3;
  localparam int SPC_PIN_W = 4;

  // pin slots; the i2c pair shares the first two slots
  localparam int SPC_PIN_SCK = 0;
  localparam int SPC_PIN_SDI = 1;
  localparam int SPC_PIN_SDO = 2;
  localparam int SPC_PIN_SS = 3;
  localparam int SPC_PIN_SCL = 0;
  localparam int SPC_PIN_SDA = 1;

  localparam logic [SPC_CNT_W-1:0] SPC_CNT_LAST = 3'h7;
  localparam logic [SPC_CNT_W-1:0] SPC_CNT_RST = 3'h0;
  localparam logic [SPC_BYTE_W-1:0] SPC_BYTE_RST = 8'h00;
  localparam logic SPC_FLAG_RST = 1'b0;
  localparam logic SPC_EN_RST = 1'b0;

  typedef enum logic [1:0] {
    SPC_SPI_MASTER,
    SPC_SPI_SLAVE,
    SPC_I2C_MASTER,
    SPC_I2C_SLAVE
  } spc_mode_t;

endpackage

//--- hdl/spc_link_shift.sv
`timescale 1ns/1ps
module spc_link_shift import spc_pkg::*; (
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  input wire logic sdi_i,
  input wire logic [SPC_BYTE_W-1:0] tx_byte_i,
  output logic sdo_o,
  output logic done_tgl_o,
  output logic [SPC_BYTE_W-1:0] rx_byte_o
);

  logic [SPC_CNT_W-1:0] cnt_q, cnt_d;
  logic [SPC_BYTE_W-1:0] shift_q, shift_d;
  logic [SPC_BYTE_W-1:0] txsh_q, txsh_d;
  logic [SPC_BYTE_W-1:0] rx_q, rx_d;
  logic tgl_q, tgl_d;

  // tx byte is held still by the system side while a byte is in flight in every mode but spi master; it is read at count zero alone
  always_comb begin
    cnt_d = cnt_q + 3'h1;
    shift_d = {shift_q[SPC_BYTE_W-2:0], sdi_i};
    txsh_d = {txsh_q[SPC_BYTE_W-2:0], 1'b0};
    rx_d = rx_q;
    tgl_d = tgl_q;
    if (cnt_q == SPC_CNT_RST) begin
      txsh_d = {tx_byte_i[SPC_BYTE_W-2:0], 1'b0};
    end
    if (cnt_q == SPC_CNT_LAST) begin
      rx_d = {shift_q[SPC_BYTE_W-2:0], sdi_i};
      tgl_d = ~tgl_q;
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      cnt_q <= SPC_CNT_RST;
      shift_q <= SPC_BYTE_RST;
      txsh_q <= SPC_BYTE_RST;
      rx_q <= SPC_BYTE_RST;
      tgl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      txsh_q <= txsh_d;
      rx_q <= rx_d;
      tgl_q <= tgl_d;
    end
  end

  assign sdo_o = (cnt_q == SPC_CNT_RST) ? tx_byte_i[SPC_BYTE_W-1] : txsh_q[SPC_BYTE_W-1];
  assign done_tgl_o = tgl_q;
  assign rx_byte_o = rx_q;

endmodule

//--- hdl/spc_ctrl_flags.sv
`timescale 1ns/1ps
module spc_ctrl_flags import spc_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire spc_mode_t mode_i,
  input wire logic serial_port_enable_i,
  input wire logic i2c_bus_idle_i,
  input wire logic i2c_tx_i,
  input wire logic tx_write_i,
  input wire logic [SPC_BYTE_W-1:0] tx_data_i,
  input wire logic rx_read_i,
  input wire logic write_collision_flag_clear_i,
  input wire logic ov_clear_i,
  input wire logic [SPC_PIN_W-1:0] pin_in_i,
  input wire logic [SPC_PIN_W-1:0] gpio_out_i,
  input wire logic [SPC_PIN_W-1:0] gpio_oe_i,
  output logic write_collision_flag_o,
  output logic receive_overflow_flag_o,
  output logic [SPC_BYTE_W-1:0] serial_data_buffer_o,
  output logic rx_full_o,
  output logic tx_busy_o,
  output logic port_enabled_o,
  output logic [SPC_PIN_W-1:0] pin_out_o,
  output logic [SPC_PIN_W-1:0] pin_oe_o,
  output logic [SPC_PIN_W-1:0] gpio_in_o
);

  function automatic logic is_i2c(input spc_mode_t m);
    return (m == SPC_I2C_MASTER) || (m == SPC_I2C_SLAVE);
  endfunction

  function automatic logic is_slave(input spc_mode_t m);
    return (m == SPC_SPI_SLAVE) || (m == SPC_I2C_SLAVE);
  endfunction

  logic en_q, en_d;
  logic write_collision_flag_q, write_collision_flag_d;
  logic ov_q, ov_d;
  logic full_q, full_d;
  logic busy_q, busy_d;
  logic [SPC_BYTE_W-1:0] rxbuf_q, rxbuf_d;
  logic [SPC_BYTE_W-1:0] txbuf_q, txbuf_d;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic [SPC_PIN_W-1:0] pin_s1_q, pin_s2_q;
  logic link_rst_n;
  logic link_sdo;
  logic link_tgl;
  logic [SPC_BYTE_W-1:0] link_rx;
  logic done_evt;
  logic wr_collide;
  logic ov_event;

  // link side is held in reset while the port is off, so a stopped peer clock
  // leaves no half-counted byte behind
  assign link_rst_n = reset_n_i & en_q;

  spc_link_shift u_link (
    .link_clk_i(link_clk_i),
    .link_rst_n_i(link_rst_n),
    .sdi_i(pin_in_i[SPC_PIN_SDI]),
    .tx_byte_i(txbuf_q),
    .sdo_o(link_sdo),
    .done_tgl_o(link_tgl),
    .rx_byte_o(link_rx)
  );

  // disabling resets the link toggle; without the gate that reset would look like a
  // finished byte and load a zero into the receive buffer
  assign done_evt = en_q && (tgl_s2_q ^ tgl_s3_q);

  always_comb begin
    wr_collide = 1'b0;
    case (mode_i)
      SPC_I2C_MASTER: wr_collide = !i2c_bus_idle_i;
      SPC_SPI_SLAVE, SPC_I2C_SLAVE: wr_collide = busy_q;
      SPC_SPI_MASTER: wr_collide = 1'b0;
      default: wr_collide = 1'b0;
    endcase
  end

  // spi master starts each byte itself, so a stale buffer is simply replaced
  always_comb begin
    ov_event = 1'b0;
    case (mode_i)
      SPC_SPI_SLAVE: ov_event = done_evt && full_q;
      SPC_SPI_MASTER: ov_event = 1'b0;
      SPC_I2C_MASTER, SPC_I2C_SLAVE: ov_event = done_evt && full_q && !i2c_tx_i;
      default: ov_event = 1'b0;
    endcase
  end

  always_comb begin
    en_d = serial_port_enable_i;
    // set wins over a clear in the same cycle
    write_collision_flag_d = (write_collision_flag_q && !write_collision_flag_clear_i) || (en_q && tx_write_i && wr_collide);
    ov_d = (ov_q && !ov_clear_i) || (en_q && ov_event);
    txbuf_d = txbuf_q;
    busy_d = busy_q;
    if (done_evt) begin
      busy_d = 1'b0;
    end
    if (en_q && tx_write_i && !wr_collide) begin
      txbuf_d = tx_data_i;
      busy_d = 1'b1;
    end
    rxbuf_d = rxbuf_q;
    full_d = full_q && !rx_read_i;
    if (done_evt && !ov_event) begin
      rxbuf_d = link_rx;
      full_d = 1'b1;
    end else if (ov_event) begin
      full_d = 1'b1;
    end
    if (!en_q) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= SPC_EN_RST;
      write_collision_flag_q <= SPC_FLAG_RST;
      ov_q <= SPC_FLAG_RST;
      full_q <= 1'b0;
      busy_q <= 1'b0;
      rxbuf_q <= SPC_BYTE_RST;
      txbuf_q <= SPC_BYTE_RST;
    end else begin
      en_q <= en_d;
      write_collision_flag_q <= write_collision_flag_d;
      ov_q <= ov_d;
      full_q <= full_d;
      busy_q <= busy_d;
      rxbuf_q <= rxbuf_d;
      txbuf_q <= txbuf_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      tgl_s1_q <= link_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      pin_s1_q <= pin_in_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // direction stays with software in spi modes; in i2c modes the port gates the SDA enable and turns the SCL enable off
  always_comb begin
    pin_out_o = gpio_out_i;
    pin_oe_o = gpio_oe_i;
    if (en_q && !is_i2c(mode_i)) begin
      pin_out_o[SPC_PIN_SDO] = link_sdo;
    end else if (en_q) begin
      // open drain: only a zero is driven on the data line
      pin_out_o[SPC_PIN_SDA] = 1'b0;
      pin_oe_o[SPC_PIN_SDA] = gpio_oe_i[SPC_PIN_SDA] && !link_sdo;
      pin_out_o[SPC_PIN_SCL] = 1'b0;
      pin_oe_o[SPC_PIN_SCL] = 1'b0;
    end
  end

  assign write_collision_flag_o = write_collision_flag_q;
  assign receive_overflow_flag_o = ov_q;
  assign serial_data_buffer_o = rxbuf_q;
  assign rx_full_o = full_q;
  assign tx_busy_o = busy_q;
  assign port_enabled_o = en_q;
  assign gpio_in_o = pin_s2_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  write_collision_flag_i2c_mst_a: assert property (
    en_q && tx_write_i && mode_i == SPC_I2C_MASTER && !i2c_bus_idle_i
    |=> write_collision_flag_o && $stable(txbuf_q))
    else $error("i2c master write while bus busy did not set collision");

  write_collision_flag_slave_a: assert property (
    en_q && tx_write_i && is_slave(mode_i) && busy_q |=> write_collision_flag_o)
    else $error("slave write during shift did not set collision");

  write_collision_flag_sticky_a: assert property (
    write_collision_flag_o && !write_collision_flag_clear_i |=> write_collision_flag_o)
    else $error("collision flag cleared without software");

  ov_sticky_a: assert property (
    receive_overflow_flag_o && !ov_clear_i |=> receive_overflow_flag_o)
    else $error("overflow flag cleared without software");

  ov_spi_slave_a: assert property (
    en_q && done_evt && full_q && mode_i == SPC_SPI_SLAVE |=> receive_overflow_flag_o)
    else $error("spi slave overflow not flagged");

  ov_spi_mst_a: assert property (
    mode_i == SPC_SPI_MASTER && !receive_overflow_flag_o |=> !receive_overflow_flag_o)
    else $error("spi master raised overflow");

  ov_i2c_rx_a: assert property (
    en_q && done_evt && full_q && is_i2c(mode_i) && !i2c_tx_i |=> receive_overflow_flag_o)
    else $error("i2c receive overflow not flagged");

  buf_keep_a: assert property (
    ov_event |=> $stable(serial_data_buffer_o) && rx_full_o)
    else $error("buffer overwritten on overflow");

  pins_off_a: assert property (
    !en_q |-> pin_out_o == gpio_out_i && pin_oe_o == gpio_oe_i)
    else $error("disabled port still owns pins");

  pins_spi_a: assert property (
    en_q && !is_i2c(mode_i) |-> pin_out_o[SPC_PIN_SDO] == link_sdo)
    else $error("spi data out not routed");

  pins_i2c_a: assert property (
    en_q && is_i2c(mode_i) |-> !pin_out_o[SPC_PIN_SDA] && !pin_oe_o[SPC_PIN_SCL])
    else $error("i2c pins not routed");

  rx_byte_c: cover property (done_evt && !full_q ##[1:40] rx_read_i);
  ov_seen_c: cover property (ov_event ##1 ov_clear_i);
  write_collision_flag_seen_c: cover property (en_q && tx_write_i && wr_collide);
  tx_done_c: cover property (busy_q ##[1:400] !busy_q);

endmodule

//--- test/spc_peer.sv
`timescale 1ns/1ps
module spc_peer (
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [7:0] got;
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    got = 8'h00;
  end
  // clock stands still between frames; idle data shows the inverse bit
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = b[i];
      #15;
      got = {got[6:0], sdo_i};
      sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    sdi_o = ~b[0];
  endtask
endmodule

//--- test/test_serial_port_ctrl_flags.sv
`timescale 1ns/1ps
module test_serial_port_ctrl_flags import spc_pkg::*; ;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  spc_mode_t mode = SPC_SPI_SLAVE;
  logic en = 1'b0, idle = 1'b1, txw = 1'b0;
  logic i2c_tx = 1'b0;
  logic [2:0] ctl = 3'h0;
  logic [7:0] txd = 8'h00, t;
  logic [3:0] pin_r = 4'h0, go = 4'h0, goe = 4'h0;
  logic write_collision_flag, ov, full, busy, pen, sck, sdi;
  logic [7:0] buf_o;
  logic [3:0] pout, poe, gin, pin_in;
  int compares = 0, n_mismatch = 0, cyc = 0, seed = 49;
  int m_buf = 0, m_full = 0, m_ov = 0;
  assign pin_in = en ? {2'b00, sdi, sck} : pin_r;
  always #5 clk_sys_i = ~clk_sys_i;
  spc_peer u_spc_peer (.sck_o(sck), .sdi_o(sdi), .sdo_i(pout[SPC_PIN_SDO]));
  spc_ctrl_flags u_spc_ctrl_flags (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link_clk_i(sck), .mode_i(mode),
    .serial_port_enable_i(en), .i2c_bus_idle_i(idle), .i2c_tx_i(i2c_tx),
    .tx_write_i(txw), .tx_data_i(txd), .rx_read_i(ctl[2]), .write_collision_flag_clear_i(ctl[1]),
    .ov_clear_i(ctl[0]), .pin_in_i(pin_in), .gpio_out_i(go), .gpio_oe_i(goe),
    .write_collision_flag_o(write_collision_flag), .receive_overflow_flag_o(ov),
    .serial_data_buffer_o(buf_o), .rx_full_o(full), .tx_busy_o(busy),
    .port_enabled_o(pen), .pin_out_o(pout), .pin_oe_o(poe), .gpio_in_o(gin));
  task end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_sys_i);
    // look once the edge's updates have settled
    #1;
  endtask
  task wr(input logic [7:0] d);
    @(posedge clk_sys_i);
    txw <= 1'b1;
    txd <= d;
    @(posedge clk_sys_i);
    txw <= 1'b0;
    #1;
  endtask
  task pl(input logic [2:0] v);
    @(posedge clk_sys_i);
    ctl <= v;
    @(posedge clk_sys_i);
    ctl <= 3'h0;
  endtask
  // model: a full buffer drops the byte except in spi master, which overwrites
  task rx(input logic [7:0] b);
    u_spc_peer.send(b);
    tk(10);
    if (m_full != 0 && mode != SPC_SPI_MASTER) m_ov = 1;
    else begin
      m_buf = b;
      m_full = 1;
    end
    chk(buf_o, m_buf);
    chk(full, m_full);
    chk(ov, m_ov);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    tk(1);
    chk({write_collision_flag, ov, full, busy, pen}, 8'h00);
    chk(buf_o, 8'h00);
    repeat (4) begin
      @(posedge clk_sys_i);
      go <= 4'($random(seed));
      goe <= 4'($random(seed));
      pin_r <= 4'($random(seed));
      tk(3);
      chk(pout, go);
      chk(poe, goe);
      chk(gin, pin_r);
    end
    @(posedge clk_sys_i);
    goe <= 4'h4;
    en <= 1'b1;
    tk(3);
    chk(pen, 1'b1);
    t = $random(seed);
    wr(t);
    chk(busy, 1'b1);
    wr(~t);
    tk(1);
    chk(write_collision_flag, 1'b1);
    rx($random(seed));
    chk(u_spc_peer.got, t);
    rx($random(seed));
    tk(20);
    chk({write_collision_flag, ov}, 8'h03);
    pl(3'h3);
    m_ov = 0;
    tk(1);
    chk({write_collision_flag, ov}, 8'h00);
    pl(3'h4);
    m_full = 0;
    mode <= SPC_SPI_MASTER;
    rx($random(seed));
    rx($random(seed));
    pl(3'h4);
    m_full = 0;
    // i2c transmit never raises the overflow flag; it is run here only with an empty buffer
    mode <= SPC_I2C_SLAVE;
    i2c_tx <= 1'b1;
    tk(2);
    chk(pen, 1'b1);
    chk(poe, 4'h4);
    chk(pout, {go[3:2], 2'b00});
    rx($random(seed));
    @(posedge clk_sys_i);
    i2c_tx <= 1'b0;
    rx($random(seed));
    pl(3'h1);
    m_ov = 0;
    mode <= SPC_I2C_MASTER;
    idle <= 1'b0;
    wr($random(seed));
    tk(1);
    chk(write_collision_flag, 1'b1);
    pl(3'h2);
    idle <= 1'b1;
    wr($random(seed));
    tk(1);
    chk(write_collision_flag, 1'b0);
    @(posedge clk_sys_i);
    en <= 1'b0;
    tk(3);
    chk(pen, 1'b0);
    chk(pout, go);
    end_sim;
  end
endmodule
